// [rtl/port_two_pkg.sv]
// constants shared by the four-pin port block
package port_two_pkg;
   // register word offsets as printed (not multiples of four, so byte address = 4 * index)
   localparam logic [7:0] DATA_IDX      = 8'h00;  // port_two_latch
   localparam logic [7:0] PIN0_CTRL_IDX = 8'h10;  // pin0_ctrl_reg
   localparam logic [7:0] PIN1_CTRL_IDX = 8'h11;  // pin1_ctrl_reg
   localparam logic [7:0] PIN2_CTRL_IDX = 8'h12;  // pin2_ctrl_reg
   localparam logic [7:0] PIN3_CTRL_IDX = 8'h13;  // pin3_ctrl_reg
   localparam logic [7:0] PULL_CTRL_IDX = 8'h20;  // pull_sense_ctrl_reg
   localparam logic [7:0] IRQ_STAT_IDX  = 8'h21;  // sticky event status
   localparam logic [7:0] IRQ_MASK_IDX  = 8'h22;  // event mask
   // control register field positions
   localparam int MOD_BIT = 0;  // termination / drive choice
   localparam int DIR_BIT = 1;  // io way
   localparam int SMP_BIT = 2;  // sample clock choice
   localparam int IE_BIT  = 3;  // irq allow
   localparam int PUD_BIT = 2;  // pull polarity bit of pull control register
   // reset values
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [3:0] DATA_RESET = 4'h0;
   localparam logic [3:0] PULL_RESET = 4'h0;
   // timing: 64 Hz tick derived from 10 MHz clock
   localparam int CLK_HZ        = 10_000_000;
   localparam int TICK_HZ       = 64;
   localparam int TICK_CYCLES   = CLK_HZ / TICK_HZ;  // 156250 cycles per tick
endpackage

// [rtl/tick_divider.sv]
// divider that makes a one-cycle enable pulse every PERIOD cycles
`timescale 1ns/1ps
module tick_divider #(
   parameter int PERIOD = port_two_pkg::TICK_CYCLES  // cycles between pulses
) (
   input  wire logic clk,
   input  wire logic reset,
   output logic      tick
);
   logic [31:0] count;  // cycles since last pulse

   // free-running count, pulse on wrap
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         count <= 32'h0000_0000;
         tick  <= 1'b0;
      end
      else if (count == 32'(PERIOD - 1))
      begin
         count <= 32'h0000_0000;
         tick  <= 1'b1;
      end
      else
      begin
         count <= count + 32'h0000_0001;
         tick  <= 1'b0;
      end
   end
endmodule

// [rtl/pin_event_detect.sv]
// per-pin change detector sampling on the chosen clock
`timescale 1ns/1ps
module pin_event_detect (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic level,       // already synchronised pin level
   input  wire logic tick,        // 64 Hz enable pulse
   input  wire logic use_sysclk,  // 1: sample every cycle
   input  wire logic allow,       // interrupt enable of the pin
   output logic      change       // one-cycle change pulse
);
   logic sampled;  // last value taken at a sample point
   logic primed;   // first sample seen since reset
   logic take;     // sample point this cycle

   assign take = use_sysclk | tick;

   // sample, compare with previous sample
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sampled <= 1'b0;
         primed  <= 1'b0;
         change  <= 1'b0;
      end
      else
      begin
         change <= 1'b0;
         if (take)
         begin
            sampled <= level;
            primed  <= 1'b1;
            // gated by enable so a disabled pin raises nothing
            change  <= primed & allow & (level != sampled);
         end
      end
   end
endmodule

// [rtl/port_two.sv]
// four-pin general purpose port with per-pin control and pin-change interrupts
// What this block does
// - irq allow bit gates pin interrupts
// - sample clock: 64 Hz tick or system clock
// - direction bit: input or output from latch
// - input: terminated or high impedance
// - output: push-pull or open drain
// - control registers reset to zero
// - data latch drives output pins
// - data read returns pin level on inputs
// - pull polarity from separate control bit
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module port_two #(
   parameter int TICK_PERIOD = port_two_pkg::TICK_CYCLES  // 64 Hz divider length
) (
   input  wire logic        clk,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // pins
   input  wire logic [3:0]  pin_in,        // pad levels, asynchronous
   output logic [3:0]       pin_out,       // value driven
   output logic [3:0]       pin_oe,        // high while driving
   output logic [3:0]       pull_enable,   // termination resistor on
   output logic             pull_polarity, // 1: pull up, 0: pull down
   output logic             irq
);
   logic [3:0] ctrl [4];       // per-pin control registers
   logic [3:0] port_two_latch; // output data latch
   logic [3:0] pull_ctrl;      // pull_sense_ctrl_reg
   logic [3:0] irq_stat;       // sticky events
   logic [3:0] irq_mask;       // 1 lets event reach irq
   logic [3:0] sync1;          // first synchroniser stage
   logic [3:0] sync2;          // synchronised pin levels
   logic [3:0] change;         // per-pin change pulses
   logic       tick;           // 64 Hz enable
   logic [9:0] idx;            // word index
   logic       wr_en;          // write at access end
   logic       rd_sel;         // read setup phase
   logic       mapped;         // address hits a register
   logic [3:0] next_rd;        // read value
   logic [3:0] dir;            // per-pin direction
   logic [3:0] mode;           // per-pin mode bit

   assign idx    = paddr[11:2];
   assign wr_en  = psel & penable & pwrite & pready;
   assign rd_sel = psel & ~penable & ~pwrite;

   // gather direction and mode bits
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         dir[i]  = ctrl[i][port_two_pkg::DIR_BIT];
         mode[i] = ctrl[i][port_two_pkg::MOD_BIT];
      end
   end

   // address decode, unaligned low bits ignored
   always_comb
   begin
      mapped  = 1'b1;
      next_rd = 4'h0;
      case (idx[7:0])
         // inputs show pin level, outputs their latch
         port_two_pkg::DATA_IDX:
            next_rd = (dir & port_two_latch) | (~dir & sync2);
         port_two_pkg::PIN0_CTRL_IDX, port_two_pkg::PIN1_CTRL_IDX,
         port_two_pkg::PIN2_CTRL_IDX, port_two_pkg::PIN3_CTRL_IDX:
            next_rd = 4'h0;  // write only, reads zero
         port_two_pkg::PULL_CTRL_IDX: next_rd = pull_ctrl;
         port_two_pkg::IRQ_STAT_IDX:  next_rd = irq_stat;
         port_two_pkg::IRQ_MASK_IDX:  next_rd = irq_mask;
         default:                     mapped  = 1'b0;
      endcase
      if (idx[9:8] != 2'b00)
      begin
         mapped = 1'b0;
      end
   end

   // apb answer: one wait-free access phase, read data registered in setup
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         // ready during the access phase only
         // pslverr only flags a miss; control writes decode idx[9:2], other writes an exact index
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (rd_sel)
         begin
            prdata <= {28'h000_0000, next_rd};
         end
      end
   end

   // per-pin control registers, cleared by reset
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < 4; i++)
         begin
            ctrl[i] <= port_two_pkg::CTRL_RESET;
         end
      end
      else if (wr_en && idx[9:2] == {2'b00, port_two_pkg::PIN0_CTRL_IDX[7:2]})
      begin
         // the low two index bits pick the pin
         ctrl[idx[1:0]] <= pwdata[3:0];
      end
   end

   // data latch and pull control
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         port_two_latch <= port_two_pkg::DATA_RESET;
         pull_ctrl      <= port_two_pkg::PULL_RESET;
      end
      else if (wr_en)
      begin
         // writes land in the latch even for input pins, so a later switch is glitch free
         if (idx == 10'(port_two_pkg::DATA_IDX))
         begin
            port_two_latch <= pwdata[3:0];
         end
         if (idx == 10'(port_two_pkg::PULL_CTRL_IDX))
         begin
            pull_ctrl <= pwdata[3:0];
         end
      end
   end

   // pad control derived from direction, mode and latch
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pin_out       <= 4'h0;
         pin_oe        <= 4'h0;
         pull_enable   <= 4'h0;
         pull_polarity <= 1'b0;
      end
      else
      begin
         // pads follow register changes one cycle late
         for (int i = 0; i < 4; i++)
         begin
            if (dir[i])
            begin
               // open drain drives only a low
               pin_out[i] <= mode[i] ? 1'b0 : port_two_latch[i];
               pin_oe[i]  <= mode[i] ? ~port_two_latch[i] : 1'b1;
               pull_enable[i] <= 1'b0;
            end
            else
            begin
               pin_out[i]     <= 1'b0;
               pin_oe[i]      <= 1'b0;
               pull_enable[i] <= ~mode[i];
            end
         end
         pull_polarity <= pull_ctrl[port_two_pkg::PUD_BIT];
      end
   end

   // two-stage synchroniser for the pads
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end
      else
      begin
         // only the second stage reads the first, which may be metastable
         sync1 <= pin_in;
         sync2 <= sync1;
      end
   end

   // shared 64 Hz tick
   // one divider for all pins keeps their slow samples in step
   tick_divider #(
      .PERIOD(TICK_PERIOD)
   ) u_tick (
      .clk  (clk),
      .reset(reset),
      .tick (tick)
   );

   // one change detector per pin
   // each pin keeps its own sample and prime state
   for (genvar g = 0; g < 4; g++)
   begin : g_pin
      pin_event_detect u_det (
         .clk       (clk),
         .reset     (reset),
         .level     (sync2[g]),
         .tick      (tick),
         .use_sysclk(ctrl[g][port_two_pkg::SMP_BIT]),
         .allow     (ctrl[g][port_two_pkg::IE_BIT]),
         .change    (change[g])
      );
   end

   // sticky status, write one to clear, new event wins
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         irq_stat <= 4'h0;
         irq_mask <= 4'h0;
      end
      else
      begin
         if (wr_en && idx == 10'(port_two_pkg::IRQ_STAT_IDX))
         begin
            irq_stat <= (irq_stat & ~pwdata[3:0]) | change;
         end
         else
         begin
            irq_stat <= irq_stat | change;
         end
         if (wr_en && idx == 10'(port_two_pkg::IRQ_MASK_IDX))
         begin
            irq_mask <= pwdata[3:0];
         end
      end
   end

   // level interrupt, registered
   // a flop output keeps the pin clean, at the cost of one cycle of lag
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   // checks, all on the system clock; reset parks every attempt except in a_reset_clears and the covers
   // control registers 1 to 3 come out of reset cleared
   a_reset_clears: assert property (@(posedge clk)
      $past(reset) |-> (ctrl[1] == 4'h0 && ctrl[2] == 4'h0 && ctrl[3] == 4'h0))
      else $error("control not cleared by reset");
   // a push-pull output follows the latch one cycle later
   a_dir_drives: assert property (@(posedge clk) disable iff (reset)
      (dir[1] && !mode[1]) |=> (pin_oe[1] && pin_out[1] == $past(port_two_latch[1])))
      else $error("output pin not driven from latch");
   // an input pin never drives its pad
   a_input_float: assert property (@(posedge clk) disable iff (reset)
      !dir[2] |=> !pin_oe[2])
      else $error("input pin driven");
   // open drain may drive only a low
   a_open_drain: assert property (@(posedge clk) disable iff (reset)
      pin_oe[3] && pin_out[3] |-> !$past(mode[3]))
      else $error("open drain drove high");
   // termination follows the mode bit on inputs
   a_input_term: assert property (@(posedge clk) disable iff (reset)
      (!dir[0]) |=> (pull_enable[0] == !$past(mode[0])))
      else $error("termination wrong");
   // polarity comes from the pull control register only
   a_pull_sense: assert property (@(posedge clk) disable iff (reset)
      ##1 pull_polarity == $past(pull_ctrl[2]))
      else $error("pull polarity not from pull control");
   // data read mixes pin levels and latch by direction
   a_data_read: assert property (@(posedge clk) disable iff (reset)
      (rd_sel && idx == 10'h000) |=>
         prdata[3:0] == (($past(dir) & $past(port_two_latch)) | (~$past(dir) & $past(sync2))))
      else $error("data read mismatch");
   // a data write lands in the latch
   a_latch_write: assert property (@(posedge clk) disable iff (reset)
      (wr_en && idx == 10'h000) |=> port_two_latch == $past(pwdata[3:0]))
      else $error("latch not written");
   // a disabled pin raises no change
   a_irq_gate: assert property (@(posedge clk) disable iff (reset)
      change[1] |-> $past(ctrl[1][3]))
      else $error("event from disabled pin");
   // system clock sampling turns a pad change into status two cycles on
   a_sysclk_edge: assert property (@(posedge clk) disable iff (reset)
      ($past(ctrl[1]) == 4'hC && ctrl[1] == 4'hC && $changed(sync2[1])) |-> ##2 irq_stat[1])
      else $error("system clock sampling missed change");
   // 64 Hz sampling stays quiet between ticks
   a_slow_quiet: assert property (@(posedge clk) disable iff (reset)
      (!ctrl[1][port_two_pkg::SMP_BIT] && !tick) |=> !change[1])
      else $error("change outside a sample tick");
   // a pending status bit survives until written with a one
   a_stat_sticky: assert property (@(posedge clk) disable iff (reset)
      (irq_stat[1] && !(wr_en && idx == 10'h021 && pwdata[1])) |=> irq_stat[1])
      else $error("status bit lost without a clear");
   // a new event wins over a clear in the same cycle
   a_set_wins: assert property (@(posedge clk) disable iff (reset)
      change[1] |=> irq_stat[1])
      else $error("event lost");
   // the interrupt line tracks unmasked status one cycle late
   a_irq_level: assert property (@(posedge clk) disable iff (reset)
      ##1 irq == |($past(irq_stat) & $past(irq_mask)))
      else $error("interrupt line wrong");
   // an output pin carries no termination
   a_output_noterm: assert property (@(posedge clk) disable iff (reset)
      dir[3] |=> !pull_enable[3])
      else $error("termination on an output");
   // push-pull drives the pad at either level
   a_push_pull: assert property (@(posedge clk) disable iff (reset)
      (dir[0] && !mode[0]) |=> pin_oe[0])
      else $error("push-pull output not driven");
   // a control write lands in the addressed pin's register
   a_ctrl_write: assert property (@(posedge clk) disable iff (reset)
      (wr_en && idx == 10'h012) |=> ctrl[2] == $past(pwdata[3:0]))
      else $error("control write lost");
   // ready stands for a single cycle
   a_ready_pulse: assert property (@(posedge clk) disable iff (reset)
      pready |=> !pready)
      else $error("ready held too long");
   // main scenarios
   c_write_ctrl: cover property (@(posedge clk) wr_en && idx == 10'h011);
   c_irq_fire:   cover property (@(posedge clk) $rose(irq));
   c_open_drain: cover property (@(posedge clk) dir[3] && mode[3] && pin_oe[3]);
   c_slow_event: cover property (@(posedge clk) tick ##1 change[1]);
   c_unmapped:   cover property (@(posedge clk) pready && pslverr);
endmodule

// [bench/pin_board.sv]
// board model: resolves the four pads from device drive, board drive and pulls
`timescale 1ns/1ps
module pin_board (
   input  wire logic       clk,
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic [3:0] pull_enable,
   input  wire logic       pull_polarity,
   input  wire logic [3:0] ext_val,  // board source level
   input  wire logic [3:0] ext_en,   // board source active
   output logic      [3:0] pin_in
);
   logic [3:0] float_lvl = 4'h5;  // an open pad never keeps its last level
   // flip open pads every cycle so a stale value cannot pass as a match
   always @(posedge clk)
      float_lvl <= ~float_lvl;
   // device drive wins, then board source, then resistor, else floating
   always_comb
      for (int i = 0; i < 4; i++)
         if (pin_oe[i])
            pin_in[i] = pin_out[i];
         else if (ext_en[i])
            pin_in[i] = ext_val[i];
         else if (pull_enable[i])
            pin_in[i] = pull_polarity;
         else
            pin_in[i] = float_lvl[i];
endmodule

// [bench/port_two_tb.sv]
// self-checking bench for the four-pin port block
`timescale 1ns/1ps
module port_two_tb;
   localparam int TICK = 16;   // short stand-in for the 64 Hz divider
   logic        clk, reset, psel, penable, pwrite, pready, pslverr, pull_polarity, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pin_in, pin_out, pin_oe, pull_enable, ext_val, ext_en, latch;
   logic [32:0] exp_q[$];      // {slave error, read data} per transfer
   logic [32:0] e;             // oldest note
   int          errors, n_compared;
   port_two #(.TICK_PERIOD(TICK)) i_dut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pull_enable(pull_enable), .pull_polarity(pull_polarity), .irq(irq));
   pin_board i_board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pull_enable(pull_enable), .pull_polarity(pull_polarity), .ext_val(ext_val),
      .ext_en(ext_en), .pin_in(pin_in));
   // free-running 100 ns clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(string what, logic [32:0] seen, logic [32:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(logic wr, logic [7:0] idx, logic [3:0] wd, logic [32:0] exp);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {28'h0000000, wd};
      exp_q.push_back(exp);
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      // no wait states are ever inserted; a hang is left to the watchdog
      check("pready latency", 33'(n), 33'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(logic [7:0] idx, logic [3:0] d);
      apb(1'b1, idx, d, 33'h0);
   endtask
   task automatic rd(logic [7:0] idx, logic [3:0] d);
      apb(1'b0, idx, 4'h0, {29'h0, d});
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   // all four control registers, pin 0 in the low nibble
   task automatic set_ctrl(logic [15:0] c);
      for (int i = 0; i < 4; i++)
         wr(port_two_pkg::PIN0_CTRL_IDX + 8'(i), c[4*i+:4]);
   endtask
   task automatic wait_irq(int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   // response watcher: each completed transfer consumes the oldest note
   always @(posedge clk)
      if (psel && penable && pready)
      begin
         e = exp_q.pop_front();
         if (pwrite)
            check("write response", {pslverr, 32'h0}, {e[32], 32'h0});
         else
            check("read response", {pslverr, prdata}, e);
      end
   // hang guard, far beyond the expected run
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      wrap_up();
   end
   initial
   begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      ext_val = 4'h0;
      ext_en = 4'hF;
      errors = 0;
      n_compared = 0;
      void'($urandom(32'h48C9));
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      // reset state and input read
      ext_val <= 4'($urandom());
      cyc(4);
      check("pin_oe", pin_oe, 33'h0);
      check("pull_enable", pull_enable, 33'hF);
      rd(port_two_pkg::DATA_IDX, ext_val);
      rd(port_two_pkg::PIN1_CTRL_IDX, 4'h0);
      apb(1'b0, 8'h3F, 4'h0, {1'b1, 32'h0});
      $display("test reset done");
      // push-pull then open drain, all pins outputs
      ext_en <= 4'h0;
      for (int m = 0; m < 2; m++)
      begin
         latch = 4'($urandom());
         wr(port_two_pkg::DATA_IDX, latch);
         set_ctrl({4{3'b001, m[0]}});
         cyc(2);
         check("pin_oe", pin_oe, m ? 4'(~latch) : 4'hF);
         check("pin_out", pin_out, m ? 4'h0 : latch);
         check("pull_enable", pull_enable, 33'h0);
         rd(port_two_pkg::DATA_IDX, latch);
      end
      $display("test outputs done");
      // two outputs, two inputs
      ext_en <= 4'hC;
      ext_val <= 4'($urandom());
      latch = 4'($urandom());
      wr(port_two_pkg::DATA_IDX, latch);
      set_ctrl(16'h0022);
      cyc(3);
      rd(port_two_pkg::DATA_IDX, {ext_val[3:2], latch[1:0]});
      $display("test mixed done");
      // pull polarity from the separate control bit
      ext_en <= 4'h0;
      set_ctrl(16'h0000);
      wr(port_two_pkg::PULL_CTRL_IDX, 4'h4);
      cyc(4);
      check("pull_polarity", pull_polarity, 33'h1);
      rd(port_two_pkg::DATA_IDX, 4'hF);
      wr(port_two_pkg::PULL_CTRL_IDX, 4'hB);
      cyc(4);
      check("pull_polarity", pull_polarity, 33'h0);
      rd(port_two_pkg::DATA_IDX, 4'h0);
      set_ctrl(16'h1111);
      cyc(2);
      check("pull_enable", pull_enable, 33'h0);
      $display("test pulls done");
      // interrupts: only pin 1 allowed, system clock sampling
      ext_en <= 4'hF;
      ext_val <= 4'h0;
      set_ctrl(16'h44C4);
      wr(port_two_pkg::IRQ_MASK_IDX, 4'hF);
      cyc(6);
      wr(port_two_pkg::IRQ_STAT_IDX, 4'hF);
      cyc(2);
      check("irq", irq, 33'h0);
      ext_val <= 4'h3;
      wait_irq(10);
      check("irq", irq, 33'h1);
      rd(port_two_pkg::IRQ_STAT_IDX, 4'h2);
      wr(port_two_pkg::IRQ_STAT_IDX, 4'h2);
      cyc(2);
      check("irq", irq, 33'h0);
      wr(port_two_pkg::IRQ_MASK_IDX, 4'hD);
      ext_val <= 4'h1;
      cyc(8);
      check("irq", irq, 33'h0);
      rd(port_two_pkg::IRQ_STAT_IDX, 4'h2);
      wr(port_two_pkg::IRQ_STAT_IDX, 4'hF);
      wr(port_two_pkg::IRQ_MASK_IDX, 4'hF);
      // pin 1 on the slow tick
      wr(port_two_pkg::PIN1_CTRL_IDX, 4'h8);
      cyc(2 * TICK);
      wr(port_two_pkg::IRQ_STAT_IDX, 4'hF);
      ext_val <= 4'h3;
      wait_irq(3 * TICK);
      check("irq", irq, 33'h1);
      $display("test interrupts done");
      wrap_up();
   end
endmodule
